// File: can_node_baud_select.v
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "can_cfg_map.vh"

module can_node_baud_select (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rd_data_r,
    input  wire [3:0]  config_selector_switch,
    input  wire        cfg_file_valid,
    input  wire [7:0]  cfg_file_baud,
    input  wire [7:0]  cfg_file_node,
    input  wire [15:0] statusword,
    output reg  [6:0]  node_id_r,
    output reg  [9:0]  bit_rate_kbd_r,
    output reg         cfg_ready_r
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam ST_RUN   = 3'h0;
    localparam ST_INIT  = 3'h1;
    localparam ST_READ  = 3'h2;
    localparam ST_FILE  = 3'h3;
    localparam ST_APPLY = 3'h4;
    localparam ST_STORE = 3'h5;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Decode a stored baud code into kBd; anything unknown runs at 1000.
    function [9:0] baud_kbd;
        input [7:0] code;
        begin
            case (code)
                8'h81:   baud_kbd = 10'h00A;
                8'h82:   baud_kbd = 10'h014;
                8'h83:   baud_kbd = 10'h032;
                8'h84:   baud_kbd = 10'h07D;
                8'h85:   baud_kbd = 10'h0FA;
                8'h86:   baud_kbd = 10'h1F4;
                8'h87:   baud_kbd = `DEF_KBD;
                8'h88:   baud_kbd = `DEF_KBD;
                default: baud_kbd = `DEF_KBD;
            endcase
        end
    endfunction

    // Pick the object that belongs to a memory slot.
    function [7:0] obj_sel;
        input [1:0] idx;
        input [7:0] b;
        input [7:0] n;
        input [7:0] e;
        input [7:0] o;
        begin
            case (idx)
                `MEM_BAUD:  obj_sel = b;
                `MEM_NODE:  obj_sel = n;
                `MEM_OFS_EN: obj_sel = e;
                default:    obj_sel = o;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg  [2:0]  state_r;       // Loader state.
    reg  [2:0]  idx_r;         // Memory slot counter, one beyond the last read.
    reg  [7:0]  baud_obj_r;    // Working baud object.
    reg  [7:0]  node_obj_r;    // Working node object.
    reg  [7:0]  ofs_en_r;      // Offset mode enable object.
    reg  [7:0]  ofs_base_r;    // Offset base object.
    reg         stored_r;      // Stored values are present.
    reg         comm_req_r;    // Reset comm waits for the loader.
    reg  [3:0]  sw_meta_r;     // First switch synchroniser stage.
    reg  [3:0]  sw_sync_r;     // Second switch synchroniser stage.
    reg  [31:0] req0_r;        // Probe request bytes 0..3.
    reg  [31:0] rsp0_r;        // Probe answer bytes 0..3.
    reg  [31:0] rsp1_r;        // Probe answer bytes 4..7.
    reg         sdo_done_r;    // An answer is ready.
    reg         sdo_bad_r;     // The last request was not understood.
    wire [7:0]  mem_rd;        // Registered memory data.
    wire        mem_wr;        // Memory write enable.
    wire [1:0]  mem_addr;      // Memory address.
    wire [7:0]  mem_wdata;     // Memory write data.
    wire        wr_work;       // Working objects may be written.
    wire [3:0]  sw;            // Synchronised switch value.
    wire        ofs_mode;      // Offset mode is on.
    reg  [6:0]  node_nxt;      // Node identifier being formed.
    reg  [9:0]  kbd_nxt;       // Bit rate being formed.
    reg  [31:0] rd_nxt;        // Read data being formed.

    assign sw        = sw_sync_r;
    assign ofs_mode  = (ofs_en_r == `OFS_ON);
    assign wr_work   = wr_stb && (state_r == ST_RUN);
    assign mem_wr    = (state_r == ST_STORE);
    assign mem_addr  = idx_r[1:0];
    assign mem_wdata = obj_sel(idx_r[1:0], baud_obj_r, node_obj_r, ofs_en_r, ofs_base_r);

    // Store keeps non-volatile copies of the objects.
    cfg_store_mem u_mem (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .wr_en     (mem_wr),
        .addr      (mem_addr),
        .wr_data   (mem_wdata),
        .rd_data_r (mem_rd)
    );

    // ------------------------------------------------------------------------
    // Switch synchroniser
    // ------------------------------------------------------------------------
    // The switch is a pin; two stages keep the loader off a moving value.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sw_meta_r <= 4'h0;
            sw_sync_r <= 4'h0;
        end else begin
            sw_meta_r <= config_selector_switch;
            sw_sync_r <= sw_meta_r;
        end
    end

    // ------------------------------------------------------------------------
    // Effective selection
    // ------------------------------------------------------------------------
    // The switch is applied last; it overrides the node object except at 0, and at 8 in plain mode.
    always @* begin
        node_nxt = node_obj_r[6:0];
        kbd_nxt  = `DEF_KBD;
        if (sw == 4'h1) begin
            node_nxt = `DEF_NODE;
            kbd_nxt  = `DEF_KBD;
        end else if (ofs_mode) begin
            if (sw == 4'h0) begin
                node_nxt = node_obj_r[6:0];
                kbd_nxt  = `DEF_KBD;
            end else begin
                node_nxt = ofs_base_r[6:0] + {3'h0, sw};
                kbd_nxt  = baud_kbd(baud_obj_r);
            end
        end else begin
            if (sw[2:0] == 3'h0) begin
                node_nxt = node_obj_r[6:0];
            end else begin
                node_nxt = {4'h0, sw[2:0]};
            end
            if (sw[3]) begin
                kbd_nxt = baud_kbd(baud_obj_r);
            end else begin
                kbd_nxt = `DEF_KBD;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Loader and store sequencer
    // ------------------------------------------------------------------------
    // The node and rate outputs change only at reset and in the apply step, so edits to the objects stay
    // dormant until they are saved and a reset comm runs the loader again.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r        <= ST_INIT;
            idx_r          <= 3'h0;
            baud_obj_r     <= `DEF_BAUD_OBJ;
            node_obj_r     <= `DEF_NODE_OBJ;
            ofs_en_r       <= `DEF_OFS_EN;
            ofs_base_r     <= `DEF_OFS_BASE;
            stored_r       <= 1'b0;
            comm_req_r     <= 1'b0;
            node_id_r      <= `DEF_NODE;
            bit_rate_kbd_r <= `DEF_KBD;
            cfg_ready_r    <= 1'b0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (comm_req_r) begin
                        comm_req_r  <= 1'b0;
                        cfg_ready_r <= 1'b0;
                        state_r     <= ST_INIT;
                    end else if (wr_stb && addr == `A_STORE
                                 && wr_data == `STORE_SIG) begin
                        idx_r   <= 3'h0;
                        state_r <= ST_STORE;
                    end else if (wr_work) begin
                        case (addr)
                            `A_BAUD_OBJ: baud_obj_r <= wr_data[7:0];
                            `A_NODE_OBJ: node_obj_r <= wr_data[7:0];
                            `A_OFS_EN:   ofs_en_r   <= wr_data[7:0];
                            `A_OFS_BASE: ofs_base_r <= wr_data[7:0];
                            default: begin
                                // Other addresses leave the objects alone.
                            end
                        endcase
                    end
                end
                ST_INIT: begin
                    baud_obj_r <= `DEF_BAUD_OBJ;
                    node_obj_r <= `DEF_NODE_OBJ;
                    ofs_en_r   <= `DEF_OFS_EN;
                    ofs_base_r <= `DEF_OFS_BASE;
                    idx_r      <= 3'h0;
                    state_r    <= ST_READ;
                end
                ST_READ: begin
                    // Data for slot idx-1 arrive while slot idx is addressed.
                    if (idx_r != 3'h0 && stored_r) begin
                        case (idx_r[1:0] - 2'h1)
                            `MEM_BAUD:   baud_obj_r <= mem_rd;
                            `MEM_NODE:   node_obj_r <= mem_rd;
                            `MEM_OFS_EN: ofs_en_r   <= mem_rd;
                            default:     ofs_base_r <= mem_rd;
                        endcase
                    end
                    if (idx_r == 3'h4) begin
                        state_r <= ST_FILE;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                    end
                end
                ST_FILE: begin
                    if (cfg_file_valid) begin
                        baud_obj_r <= cfg_file_baud;
                        node_obj_r <= cfg_file_node;
                    end
                    state_r <= ST_APPLY;
                end
                ST_APPLY: begin
                    node_id_r      <= node_nxt;
                    bit_rate_kbd_r <= kbd_nxt;
                    cfg_ready_r    <= 1'b1;
                    state_r        <= ST_RUN;
                end
                ST_STORE: begin
                    if (idx_r == 3'h3) begin
                        stored_r <= 1'b1;
                        state_r  <= ST_RUN;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= ST_INIT;
                end
            endcase
            // A reset comm write is held while busy; set wins over clear.
            if (wr_stb && addr == `A_CMD && wr_data[`CMD_RST_COMM]) begin
                comm_req_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interface probe
    // ------------------------------------------------------------------------
    // Bytes go most significant first: byte 0 sits in bits 31..24. The
    // statusword is sent low byte first, as the fieldbus orders it.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req0_r     <= 32'h00000000;
            rsp0_r     <= 32'h00000000;
            rsp1_r     <= 32'h00000000;
            sdo_done_r <= 1'b0;
            sdo_bad_r  <= 1'b0;
        end else if (wr_stb && addr == `A_SDO_REQ0) begin
            req0_r     <= wr_data;
            sdo_done_r <= 1'b0;
        end else if (wr_stb && addr == `A_SDO_REQ1) begin
            sdo_done_r <= 1'b1;
            if (req0_r == `SDO_REQ_HI && wr_data == `SDO_REQ_LO) begin
                rsp0_r    <= `SDO_RSP_HI;
                rsp1_r    <= {statusword[7:0], statusword[15:8], 16'h0000};
                sdo_bad_r <= 1'b0;
            end else begin
                rsp0_r    <= 32'h00000000;
                rsp1_r    <= 32'h00000000;
                sdo_bad_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    // Unmapped and write-only addresses read as zero.
    always @* begin
        rd_nxt = 32'h00000000;
        case (addr)
            `A_BAUD_OBJ: rd_nxt = {24'h000000, baud_obj_r};
            `A_NODE_OBJ: rd_nxt = {24'h000000, node_obj_r};
            `A_OFS_EN:   rd_nxt = {24'h000000, ofs_en_r};
            `A_OFS_BASE: rd_nxt = {24'h000000, ofs_base_r};
            `A_STATUS:   rd_nxt = {4'h0, cfg_ready_r, stored_r, sw, bit_rate_kbd_r,
                                   1'b0, node_id_r, 1'b0, state_r};
            `A_SDO_REQ0: rd_nxt = req0_r;
            `A_SDO_RSP0: rd_nxt = rsp0_r;
            `A_SDO_RSP1: rd_nxt = rsp1_r;
            `A_SDO_STAT: rd_nxt = {30'h00000000, sdo_bad_r, sdo_done_r};
            default:     rd_nxt = 32'h00000000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= 32'h00000000;
        end else if (rd_stb) begin
            rd_data_r <= rd_nxt;
        end else begin
            rd_data_r <= 32'h00000000;
        end
    end
endmodule // can_node_baud_select

// File: can_cfg_map.vh
`ifndef CAN_CFG_MAP_VH
`define CAN_CFG_MAP_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define A_BAUD_OBJ   8'h00
`define A_NODE_OBJ   8'h04
`define A_OFS_EN     8'h08
`define A_OFS_BASE   8'h0C
`define A_STORE      8'h10
`define A_CMD        8'h14
`define A_STATUS     8'h18
`define A_SDO_REQ0   8'h1C
`define A_SDO_REQ1   8'h20
`define A_SDO_RSP0   8'h24
`define A_SDO_RSP1   8'h28
`define A_SDO_STAT   8'h2C

// ----------------------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------------------
`define STORE_SIG    32'h65766173
`define CMD_RST_COMM 0
`define DEF_NODE     7'h01
`define DEF_KBD      10'h3E8
`define DEF_NODE_OBJ 8'h7F
`define DEF_BAUD_OBJ 8'h88
`define DEF_OFS_EN   8'h00
`define DEF_OFS_BASE 8'h00
`define OFS_ON       8'h01
`define SDO_REQ_HI   32'h40416000
`define SDO_REQ_LO   32'h00000000
`define SDO_RSP_HI   32'h4B416000
`define MEM_BAUD     2'h0
`define MEM_NODE     2'h1
`define MEM_OFS_EN   2'h2
`define MEM_OFS_BASE 2'h3

`endif

// File: cfg_store_mem.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Stored configuration objects
// ----------------------------------------------------------------------------
// Four byte-wide words; read data come out of a register one cycle later.
// The array itself has no reset, as a stored value outlives a reset.
module cfg_store_mem (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire       wr_en,
    input  wire [1:0] addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data_r
);
    reg [7:0] mem [0:3]; // Object storage.

    // Write on request, always register the addressed word.
    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    // The read register starts at zero so its output is defined.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= mem[addr];
        end
    end
endmodule // cfg_store_mem

// File: can_node_baud_select_sva.sv
`timescale 1ns/1ps
`include "can_cfg_map.vh"

// ----------------------------------------------------------------------------
// Port checker for the node and bit rate loader
// ----------------------------------------------------------------------------
module can_node_baud_select_sva (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rd_data_r,
    input wire logic [3:0]  config_selector_switch,
    input wire logic        cfg_file_valid,
    input wire logic [7:0]  cfg_file_baud,
    input wire logic [7:0]  cfg_file_node,
    input wire logic [15:0] statusword,
    input wire logic [6:0]  node_id_r,
    input wire logic [9:0]  bit_rate_kbd_r,
    input wire logic        cfg_ready_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    reg [31:0] req0_r;     // Last probe request head written.
    reg        probe_ok_r; // High after a well formed probe request.

    // Tracks whether the last probe was well formed, so the answer can be judged.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req0_r     <= 32'h0;
            probe_ok_r <= 1'b0;
        end else if (wr_stb && addr == `A_SDO_REQ0) begin
            req0_r     <= wr_data;
            probe_ok_r <= 1'b0;
        end else if (wr_stb && addr == `A_SDO_REQ1) begin
            probe_ok_r <= (req0_r == `SDO_REQ_HI) && (wr_data == `SDO_REQ_LO);
        end
    end

    rst_vals_a: assert property ($rose(reset_n) |-> node_id_r == 7'h01 &&
        bit_rate_kbd_r == 10'h3E8 && !cfg_ready_r) else $error("bad values after reset");
    load_time_a: assert property ($rose(reset_n) |-> !cfg_ready_r ##[7:10] cfg_ready_r)
        else $error("loader did not finish in time");
    sw_one_a: assert property ($rose(cfg_ready_r) && config_selector_switch == 4'h1
        |-> node_id_r == 7'h01 && bit_rate_kbd_r == 10'h3E8) else $error("switch 1 not forced");
    sw_zero_a: assert property ($rose(cfg_ready_r) && config_selector_switch == 4'h0
        |-> bit_rate_kbd_r == 10'h3E8) else $error("switch 0 rate not 1000");
    rate_legal_a: assert property (cfg_ready_r |-> bit_rate_kbd_r inside
        {10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA, 10'h1F4, 10'h3E8})
        else $error("undefined bit rate");
    held_vals_a: assert property (cfg_ready_r && $past(cfg_ready_r)
        |-> $stable(node_id_r) && $stable(bit_rate_kbd_r)) else $error("values changed in run");
    rd_idle_a: assert property (!$past(rd_stb) |-> rd_data_r == 32'h0)
        else $error("read data outside answer cycle");
    unmapped_a: assert property (rd_stb && addr == 8'hFC |=> rd_data_r == 32'h0)
        else $error("unmapped read not zero");
    probe_head_a: assert property (rd_stb && addr == `A_SDO_RSP0 && probe_ok_r
        |=> rd_data_r == `SDO_RSP_HI) else $error("probe answer head wrong");
    probe_tail_a: assert property (rd_stb && addr == `A_SDO_RSP1 && probe_ok_r
        |=> rd_data_r == {statusword[7:0], statusword[15:8], 16'h0})
        else $error("probe answer status wrong");
endmodule // can_node_baud_select_sva

// File: canopen_master_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Fieldbus master stand-in: issues every access over the register port
// ----------------------------------------------------------------------------
module canopen_master_model (
    input  wire logic        clk_sys,
    output logic      [7:0]  addr,
    output logic      [31:0] wr_data,
    output logic             wr_stb,
    output logic             rd_stb,
    input  wire logic [31:0] rd_data_r
);
    // Idle bus at time zero so the block never sees an unknown strobe.
    initial begin
        addr    = 8'h00;
        wr_data = 32'h0;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
    end

    // One-cycle write; strobe drops at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
    endtask

    // One-cycle read; data are taken in the single cycle they stand.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rd_data_r;
    endtask

    // Persisting objects needs the save signature, nothing else.
    task automatic save(input logic [31:0] sig);
        wr(8'h10, sig);
    endtask

    // Interface probe: the eight request bytes go out as two words.
    task automatic probe(input logic [31:0] hi, input logic [31:0] lo);
        wr(8'h1C, hi);
        wr(8'h20, lo);
    endtask
endmodule // canopen_master_model

// File: can_node_baud_select_tb.sv
`timescale 1ns/1ps
`include "can_cfg_map.vh"
`define CHK(n, e, g) check(n, e, g)

// ----------------------------------------------------------------------------
// Self-checking bench for the node and bit rate loader
// ----------------------------------------------------------------------------
module can_node_baud_select_tb;
    logic        clk_sys;                   // 40 MHz system clock.
    logic        reset_n;                   // Asynchronous reset, active low.
    logic [3:0]  sw;                        // Hex selector switch.
    logic        fv;                        // Configuration file present.
    logic [7:0]  fb;                        // File baud code.
    logic [7:0]  fn;                        // File node value.
    logic [15:0] statusword;                // Drive status for the probe.
    wire  [7:0]  addr;                      // Bus address from the master.
    wire  [31:0] wr_data;                   // Bus write data.
    wire         wr_stb;                    // Write strobe.
    wire         rd_stb;                    // Read strobe.
    wire  [31:0] rd_data_r;                 // Read answer.
    wire  [6:0]  node_id_r;                 // Effective node id.
    wire  [9:0]  bit_rate_kbd_r;            // Effective bit rate.
    wire         cfg_ready_r;               // Loader done.
    logic [31:0] d;                         // Read result.
    int          errors;                    // Mismatch count.
    int          n_compared;                // Comparison count.
    int          i;                         // Loop index.
    int          en;                        // Expected node.
    int          ek;                        // Expected rate.

    can_node_baud_select DUT (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_r(rd_data_r),
        .config_selector_switch(sw), .cfg_file_valid(fv), .cfg_file_baud(fb),
        .cfg_file_node(fn), .statusword(statusword), .node_id_r(node_id_r),
        .bit_rate_kbd_r(bit_rate_kbd_r), .cfg_ready_r(cfg_ready_r));
    canopen_master_model m (.clk_sys(clk_sys), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_r(rd_data_r));

    // Free-running clock, 25 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Case equality so an unknown never passes for a match.
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Expected decode of a stored baud code; anything unknown runs at 1000.
    function automatic int exp_kbd(input logic [7:0] c);
        case (c)
            8'h81: exp_kbd = 10;
            8'h82: exp_kbd = 20;
            8'h83: exp_kbd = 50;
            8'h84: exp_kbd = 125;
            8'h85: exp_kbd = 250;
            8'h86: exp_kbd = 500;
            default: exp_kbd = 1000;
        endcase
    endfunction

    // Bounded wait for the loader; a hang shows up as a mismatch.
    task automatic wait_ready;
        for (int k = 0; k < 40 && cfg_ready_r !== 1'b1; k++) @(posedge clk_sys) #1;
        `CHK("ready", 1, cfg_ready_r);
    endtask

    // Power cycle with a given switch and file; the store is lost as well.
    task automatic boot(input logic [3:0] s, input logic v, input logic [7:0] b,
                        input logic [7:0] n);
        @(posedge clk_sys);
        sw      <= s;
        fv      <= v;
        fb      <= b;
        fn      <= n;
        reset_n <= 1'b0;
        @(posedge clk_sys) #1;
        `CHK("reset node", 1, node_id_r);
        `CHK("reset rate", 1000, bit_rate_kbd_r);
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_ready;
    endtask

    // Communication reset; the switch settles through its synchroniser first.
    task automatic reload(input logic [3:0] s);
        @(posedge clk_sys);
        sw <= s;
        repeat (4) @(posedge clk_sys);
        m.wr(`A_CMD, 32'h1);
        for (int k = 0; k < 5 && cfg_ready_r !== 1'b0; k++) @(posedge clk_sys) #1;
        wait_ready;
    endtask

    // Writes the four objects in one go.
    task automatic objs(input logic [7:0] b, input logic [7:0] n, input logic [7:0] e,
                        input logic [7:0] o);
        m.wr(`A_BAUD_OBJ, {24'h0, b});
        m.wr(`A_NODE_OBJ, {24'h0, n});
        m.wr(`A_OFS_EN, {24'h0, e});
        m.wr(`A_OFS_BASE, {24'h0, o});
    endtask

    // Main sequence.
    initial begin
        reset_n    = 1'b0;
        sw         = 4'h0;
        fv         = 1'b0;
        fb         = 8'h00;
        fn         = 8'h00;
        statusword = 16'hA1B2;
        errors     = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_ready;
        `CHK("sw0 node", 8'h7F, node_id_r);
        `CHK("sw0 rate", 1000, bit_rate_kbd_r);
        // Switch positions 1 to 15 with a file present: the switch has the last word, except that at 8 the file node stands.
        for (i = 1; i < 16; i++) begin
            boot(i, 1'b1, 8'h84, 8'h05);
            en = (i == 1) ? 1 : (i < 8) ? i : (i == 8) ? 5 : i - 8;
            ek = (i < 8) ? 1000 : 125;
            `CHK("plain node", en, node_id_r);
            `CHK("plain rate", ek, bit_rate_kbd_r);
        end
        // All baud codes plus one outside the decoded range.
        for (i = 0; i < 9; i++) begin
            boot(4'h8, 1'b1, (i == 8) ? 8'h00 : 8'h81 + i, 8'h05);
            `CHK("decode", exp_kbd((i == 8) ? 8'h00 : 8'h81 + i), bit_rate_kbd_r);
        end
        // A wrong signature must not persist anything.
        boot(4'h0, 1'b0, 8'h00, 8'h00);
        objs(8'h85, 8'h10, 8'h01, 8'h20);
        m.save(32'h12345678);
        `CHK("held node", 8'h7F, node_id_r);
        reload(4'h3);
        `CHK("no store", 3, node_id_r);
        // The signature persists; nothing changes until the reset command.
        objs(8'h85, 8'h10, 8'h01, 8'h20);
        m.save(`STORE_SIG);
        repeat (6) @(posedge clk_sys) #1;
        `CHK("held rate", 1000, bit_rate_kbd_r);
        `CHK("held node", 3, node_id_r);
        reload(4'h3);
        `CHK("ofs node", 8'h23, node_id_r);
        `CHK("ofs rate", 250, bit_rate_kbd_r);
        reload(4'h0);
        `CHK("ofs sw0 node", 8'h10, node_id_r);
        `CHK("ofs sw0 rate", 1000, bit_rate_kbd_r);
        // The file overrides the stored baud code.
        fv <= 1'b1;
        fb <= 8'h83;
        fn <= 8'h30;
        reload(4'h8);
        `CHK("file rate", 50, bit_rate_kbd_r);
        // An enable value other than 1 leaves offset mode off.
        fv <= 1'b0;
        m.wr(`A_OFS_EN, 32'h2);
        m.save(`STORE_SIG);
        reload(4'h3);
        `CHK("ofs off node", 3, node_id_r);
        `CHK("ofs off rate", 1000, bit_rate_kbd_r);
        // Interface probe, good and malformed, then an unmapped read.
        m.probe(`SDO_REQ_HI, `SDO_REQ_LO);
        m.rd(`A_SDO_RSP0, d);
        `CHK("rsp0", 32'h4B416000, d);
        m.rd(`A_SDO_RSP1, d);
        `CHK("rsp1", 32'hB2A10000, d);
        m.rd(`A_SDO_STAT, d);
        `CHK("sdo done", 32'h1, d);
        m.probe(32'h40416001, `SDO_REQ_LO);
        m.rd(`A_SDO_STAT, d);
        `CHK("sdo bad", 32'h3, d);
        m.rd(8'hFC, d);
        `CHK("unmapped", 32'h0, d);
        tally_and_finish;
    end

    // Hang guard, far beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        tally_and_finish;
    end
endmodule // can_node_baud_select_tb

bind can_node_baud_select can_node_baud_select_sva chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data_r(rd_data_r), .config_selector_switch(config_selector_switch),
    .cfg_file_valid(cfg_file_valid), .cfg_file_baud(cfg_file_baud),
    .cfg_file_node(cfg_file_node), .statusword(statusword), .node_id_r(node_id_r),
    .bit_rate_kbd_r(bit_rate_kbd_r), .cfg_ready_r(cfg_ready_r));
